/* shared/seecm_params.svh */
`ifndef SEECM_PARAMS_SVH
`define SEECM_PARAMS_SVH

// Array geometry.
`define SEECM_WORDS 128
`define SEECM_WORD_W 16
`define SEECM_ADDR_W 7
`define SEECM_ERASED_WORD 16'hFFFF

// Instruction layout after the start bit: 2 opcode bits, 8 address bits.
`define SEECM_CMD_BITS 10
`define SEECM_CMD_LAST 5'h09
`define SEECM_DATA_LAST 5'h0F

// Opcodes and sub-codes carried in the two top address bits of opcode 00.
`define SEECM_OPC_READ 2'h2
`define SEECM_OPC_WRITE 2'h1
`define SEECM_OPC_ERASE 2'h3
`define SEECM_SUB_WEN 2'h3
`define SEECM_SUB_FILL 2'h1
`define SEECM_SUB_CLEAR 2'h2

// Timing.
`define SEECM_CLK_PERIOD_NS 4
`define SEECM_PROG_TIME_NS 2000
`define SEECM_PROG_CYCLES ((`SEECM_PROG_TIME_NS + `SEECM_CLK_PERIOD_NS - 1) / `SEECM_CLK_PERIOD_NS)
`define SEECM_TIMER_W 12

// Read-ahead buffer.
`define SEECM_FIFO_DEPTH 8

`endif

/* shared/seecm_pkg.sv */
`include "seecm_params.svh"

package seecm_pkg;

  typedef enum logic [2:0] {
    SEECM_ST_IDLE,
    SEECM_ST_CMD,
    SEECM_ST_DATA,
    SEECM_ST_ARMED,
    SEECM_ST_BUSY,
    SEECM_ST_READ,
    SEECM_ST_WAIT
  } seecm_state_type;

  typedef enum logic [2:0] {
    SEECM_OP_READ,
    SEECM_OP_WRITE,
    SEECM_OP_ERASE,
    SEECM_OP_WEN,
    SEECM_OP_WDS,
    SEECM_OP_FILL,
    SEECM_OP_CLEAR
  } seecm_op_type;

  typedef struct packed {
    seecm_state_type state;
    seecm_op_type op;
    logic [4:0] cnt;
    logic [`SEECM_CMD_BITS-1:0] cmd;
    logic [`SEECM_ADDR_W-1:0] addr;
    logic [`SEECM_WORD_W-1:0] data;
    logic wen;
    logic rdy;
    logic stat;
    logic [`SEECM_ADDR_W-1:0] fetch_addr;
    logic [`SEECM_WORD_W-1:0] sh_word;
    logic [4:0] sh_cnt;
    logic [`SEECM_TIMER_W-1:0] timer;
    logic dout;
    logic oe_n;
    logic [`SEECM_WORDS-1:0][`SEECM_WORD_W-1:0] mem;
  } seecm_engine_state_type;

endpackage

/* shared/seecm_stream_if.sv */
`timescale 1ns/1ps

interface seecm_stream_if #(parameter int W = 16) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* core/seecm_fifo.sv */
`timescale 1ns/1ps

module seecm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  seecm_stream_if.snk wr,
  seecm_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } seecm_fifo_state_type;

  seecm_fifo_state_type r;
  seecm_fifo_state_type n;
  logic push;
  logic pop;

  assign wr.ready = (r.cnt != (AW+1)'(DEPTH));
  assign rd.valid = (r.cnt != '0);
  assign rd.data = r.mem[r.rp];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  always_comb
  begin
    n = r;
    if (flush_i)
    begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end
    else
    begin
      if (push)
      begin
        n.mem[r.wp] = wr.data;
        n.wp = r.wp + 1'b1;
      end
      if (pop)
        n.rp = r.rp + 1'b1;
      if (push && !pop)
        n.cnt = r.cnt + 1'b1;
      else if (pop && !push)
        n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= n;
  end
endmodule // seecm_fifo

/* core/seecm_pin_sync.sv */
`timescale 1ns/1ps

module seecm_pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic select_i,
  input wire logic shift_clock_i,
  input wire logic serial_in_i,
  output logic sel_o,
  output logic di_o,
  output logic sk_rise_o,
  output logic sel_fall_o
);
  typedef struct packed {
    logic sel;
    logic sel_prev;
    logic sk;
    logic sk_prev;
    logic di;
  } seecm_pin_state_type;

  seecm_pin_state_type r;
  seecm_pin_state_type n;

  // Serial input is sampled together with the clock so a bit is taken as it stood at the rising edge.
  always_comb
  begin
    n = r;
    n.sel = select_i;
    n.sel_prev = r.sel;
    n.sk = shift_clock_i;
    n.sk_prev = r.sk;
    n.di = serial_in_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= n;
  end

  assign sel_o = r.sel;
  assign di_o = r.di;
  assign sk_rise_o = r.sk & ~r.sk_prev;
  assign sel_fall_o = r.sel_prev & ~r.sel;
endmodule // seecm_pin_sync

/* core/seecm_engine.sv */
`timescale 1ns/1ps
`include "seecm_params.svh"

module seecm_engine
  import seecm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic select_i,
  input wire logic shift_clock_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o
);
  seecm_engine_state_type r;
  seecm_engine_state_type n;
  logic pin_sel;
  logic pin_di;
  logic pin_sk_rise;
  logic pin_sel_fall;
  logic [`SEECM_CMD_BITS-1:0] cmd_full;
  logic [`SEECM_WORD_W-1:0] data_full;
  seecm_op_type dec_op;

  seecm_stream_if #(.W(`SEECM_WORD_W)) fill_if ();
  seecm_stream_if #(.W(`SEECM_WORD_W)) drain_if ();

  function automatic seecm_op_type seecm_decode(input logic [`SEECM_CMD_BITS-1:0] c);
    seecm_op_type op;
    op = SEECM_OP_WDS;
    if (c[9:8] == `SEECM_OPC_READ)
      op = SEECM_OP_READ;
    else if (c[9:8] == `SEECM_OPC_WRITE)
      op = SEECM_OP_WRITE;
    else if (c[9:8] == `SEECM_OPC_ERASE)
      op = SEECM_OP_ERASE;
    else if (c[7:6] == `SEECM_SUB_WEN)
      op = SEECM_OP_WEN;
    else if (c[7:6] == `SEECM_SUB_FILL)
      op = SEECM_OP_FILL;
    else if (c[7:6] == `SEECM_SUB_CLEAR)
      op = SEECM_OP_CLEAR;
    return op;
  endfunction

  seecm_pin_sync u_pins (
    .clk_i(mclk_i),
    .rst_i(rst_i),
    .select_i(select_i),
    .shift_clock_i(shift_clock_i),
    .serial_in_i(serial_in_i),
    .sel_o(pin_sel),
    .di_o(pin_di),
    .sk_rise_o(pin_sk_rise),
    .sel_fall_o(pin_sel_fall)
  );

  // The buffer is emptied whenever no read is streaming, so a new read never sees stale words.
  seecm_fifo #(
    .WIDTH(`SEECM_WORD_W),
    .DEPTH(`SEECM_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(mclk_i),
    .rst_i(rst_i),
    .flush_i(r.state != SEECM_ST_READ),
    .wr(fill_if.snk),
    .rd(drain_if.src)
  );

  assign cmd_full = {r.cmd[`SEECM_CMD_BITS-2:0], pin_di};
  assign data_full = {r.data[`SEECM_WORD_W-2:0], pin_di};
  assign dec_op = seecm_decode(cmd_full);

  // Words are fetched ahead of the shift clock; the buffer stalls the fetcher once it is full.
  assign fill_if.valid = (r.state == SEECM_ST_READ);
  assign fill_if.data = r.mem[r.fetch_addr];
  assign drain_if.ready = (r.state == SEECM_ST_READ) && pin_sel && pin_sk_rise && !pin_sel_fall
                          && (r.sh_cnt == 5'h00);

  always_comb
  begin
    n = r;
    if (pin_sel && pin_di && pin_sk_rise)
      n.stat = 1'b0;
    if (pin_sel_fall)
    begin
      if (r.state == SEECM_ST_ARMED)
      begin
        n.state = SEECM_ST_BUSY;
        n.timer = `SEECM_TIMER_W'(`SEECM_PROG_CYCLES - 1);
        n.rdy = 1'b0;
        n.stat = 1'b1;
      end
      else if (r.state != SEECM_ST_BUSY)
        n.state = SEECM_ST_IDLE;
    end
    else if (pin_sel && pin_sk_rise)
    begin
      case (r.state)
        SEECM_ST_IDLE:
        begin
          if (pin_di)
          begin
            n.state = SEECM_ST_CMD;
            n.cnt = 5'h00;
          end
        end
        SEECM_ST_CMD:
        begin
          n.cmd = cmd_full;
          n.cnt = r.cnt + 5'h01;
          if (r.cnt == `SEECM_CMD_LAST)
          begin
            n.addr = cmd_full[`SEECM_ADDR_W-1:0];
            n.op = dec_op;
            n.cnt = 5'h00;
            n.state = SEECM_ST_WAIT;
            if (dec_op == SEECM_OP_READ)
            begin
              n.state = SEECM_ST_READ;
              n.fetch_addr = cmd_full[`SEECM_ADDR_W-1:0];
              n.sh_cnt = 5'h00;
              n.dout = 1'b0;
              n.oe_n = 1'b0;
            end
            else if (dec_op == SEECM_OP_WEN)
              n.wen = 1'b1;
            else if (dec_op == SEECM_OP_WDS)
              n.wen = 1'b0;
            else if (r.wen && (dec_op == SEECM_OP_WRITE || dec_op == SEECM_OP_FILL))
              n.state = SEECM_ST_DATA;
            else if (r.wen)
              n.state = SEECM_ST_ARMED;
          end
        end
        SEECM_ST_DATA:
        begin
          n.data = data_full;
          n.cnt = r.cnt + 5'h01;
          if (r.cnt == `SEECM_DATA_LAST)
            n.state = SEECM_ST_ARMED;
        end
        // A clock edge after the last bit means the host did not drop select in time.
        SEECM_ST_ARMED:
          n.state = SEECM_ST_WAIT;
        SEECM_ST_READ:
        begin
          if (r.sh_cnt != 5'h00)
          begin
            n.dout = r.sh_word[`SEECM_WORD_W-1];
            n.sh_word = {r.sh_word[`SEECM_WORD_W-2:0], 1'b0};
            n.sh_cnt = r.sh_cnt - 5'h01;
          end
          else if (drain_if.valid)
          begin
            n.dout = drain_if.data[`SEECM_WORD_W-1];
            n.sh_word = {drain_if.data[`SEECM_WORD_W-2:0], 1'b0};
            n.sh_cnt = `SEECM_DATA_LAST;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Programming is self-timed on the system clock and does not need the shift clock.
    if (r.state == SEECM_ST_BUSY)
    begin
      if (r.timer == '0)
      begin
        n.state = SEECM_ST_IDLE;
        n.rdy = 1'b1;
        if (r.op == SEECM_OP_WRITE)
          n.mem[r.addr] = r.data;
        else if (r.op == SEECM_OP_ERASE)
          n.mem[r.addr] = `SEECM_ERASED_WORD;
        else if (r.op == SEECM_OP_FILL)
          n.mem = {`SEECM_WORDS{r.data}};
        else if (r.op == SEECM_OP_CLEAR)
          n.mem = {`SEECM_WORDS{`SEECM_ERASED_WORD}};
      end
      else
        n.timer = r.timer - 1'b1;
    end

    if (fill_if.valid && fill_if.ready)
      n.fetch_addr = r.fetch_addr + 1'b1;

    if (n.state != SEECM_ST_READ)
    begin
      n.oe_n = ~(pin_sel & n.stat);
      n.dout = n.rdy;
    end
  end

  // Array contents come up erased because the storage is modelled in flip-flops.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.mem <= {`SEECM_WORDS{`SEECM_ERASED_WORD}};
      r.rdy <= 1'b1;
      r.dout <= 1'b1;
      r.oe_n <= 1'b1;
    end
    else
      r <= n;
  end

  assign serial_out_o = r.dout;
  assign serial_out_oe_n_o = r.oe_n;
endmodule // seecm_engine

/* tb/seecm_engine_checker.sv */
`timescale 1ns/1ps
module seecm_engine_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic select_i,
  input wire logic shift_clock_i,
  input wire logic serial_in_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_n_o
);
  logic [4:0] skh_r = 5'h00;
  logic [4:0] selh_r = 5'h00;
  logic sk_seen;
  always_ff @(posedge mclk_i)
  begin
    skh_r <= {skh_r[3:0], shift_clock_i};
    selh_r <= {selh_r[3:0], select_i};
  end
  // The pin sampler delays every effect, so a cause is looked for over the last five samples.
  assign sk_seen = |(skh_r[3:0] & ~skh_r[4:1]);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  reset_idle_a: assert property ($fell(rst_i) |-> serial_out_oe_n_o && serial_out_o)
    else $error("output not idle after reset");
  deselect_float_a: assert property (!select_i [*4] |-> serial_out_oe_n_o)
    else $error("output driven while deselected");
  drive_select_a: assert property (!serial_out_oe_n_o |-> select_i || selh_r[2:0] != 3'h0)
    else $error("output driven without select");
  drive_cause_a: assert property ($fell(serial_out_oe_n_o) |-> sk_seen || !(&selh_r))
    else $error("output driven without cause");
  lead_zero_a: assert property ($fell(serial_out_oe_n_o) && (&selh_r) |-> !serial_out_o)
    else $error("read did not start with zero");
  dout_fall_a: assert property ($fell(serial_out_o) && !serial_out_oe_n_o |-> sk_seen)
    else $error("output fell without clock rise");
  ready_hold_a: assert property (select_i && !serial_out_oe_n_o && serial_out_o && !sk_seen
    |=> serial_out_o)
    else $error("ready level dropped");
  release_cause_a: assert property ($rose(serial_out_oe_n_o) |-> sk_seen || !(&selh_r))
    else $error("output released without cause");
endmodule // seecm_engine_checker

bind seecm_engine seecm_engine_checker chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .select_i(select_i),
  .shift_clock_i(shift_clock_i), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
  .serial_out_oe_n_o(serial_out_oe_n_o));

/* tb/seecm_host.sv */
`timescale 1ns/1ps
module seecm_host (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic sel_o,
  output logic sk_o,
  output logic di_o
);
  initial
  begin
    sel_o = 1'h0;
    sk_o = 1'h0;
    di_o = 1'h0;
  end
  // The clock idles low and each level is held at least three cycles so the pin sampler sees it.
  task automatic bit_x(input logic b, output logic q);
    @(posedge clk_i) di_o <= b;
    repeat (3) @(posedge clk_i);
    sk_o <= 1'h1;
    repeat (3) @(posedge clk_i);
    q = dout_i;
    sk_o <= 1'h0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic sel(input logic v);
    @(posedge clk_i) sel_o <= v;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic cmd(input logic [10:0] c, output logic q);
    for (int i = 10; i >= 0; i--)
      bit_x(c[i], q);
  endtask
  task automatic word(input logic [15:0] d, output logic [15:0] q);
    for (int i = 15; i >= 0; i--)
      bit_x(d[i], q[i]);
  endtask
endmodule // seecm_host

/* tb/test_serial_eeprom_command_engine.sv */
`timescale 1ns/1ps
module test_serial_eeprom_command_engine;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic sel, sk, di, dout, oe_n, q;
  wire logic pin;
  logic [15:0] w;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  assign pin = oe_n ? 1'hz : dout;
  seecm_engine dut (.mclk_i(mclk_i), .rst_i(rst_i), .select_i(sel), .shift_clock_i(sk), .serial_in_i(di),
    .serial_out_o(dout), .serial_out_oe_n_o(oe_n));
  seecm_host host (.clk_i(mclk_i), .dout_i(pin), .sel_o(sel), .sk_o(sk), .di_o(di));
  initial forever #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e0, input logic [15:0] e1);
    host.sel(1'h1);
    host.cmd({4'hC, a}, q);
    chk1(q, 1'h0);
    repeat (40) @(posedge mclk_i);
    host.word(16'h0000, w);
    chk(w, e0);
    host.word(16'h0000, w);
    chk(w, e1);
    host.sel(1'h0);
  endtask
  task automatic prog(input logic [10:0] c, input logic [15:0] d, input logic has_d, input logic ok);
    host.sel(1'h1);
    host.cmd(c, q);
    if (has_d)
      host.word(d, w);
    host.sel(1'h0);
    repeat (64) @(posedge mclk_i);
    host.sel(1'h1);
    chk1(oe_n, ~ok);
    if (ok)
    begin
      chk1(dout, 1'h0);
      for (int i = 0; i < 700 && dout !== 1'h1; i++)
        @(posedge mclk_i);
      chk1(dout, 1'h1);
    end
    host.bit_x(1'h1, q);
    chk1(oe_n, 1'h1);
    host.sel(1'h0);
  endtask
  task automatic en(input logic [10:0] c);
    host.sel(1'h1);
    host.cmd(c, q);
    host.sel(1'h0);
  endtask
  task automatic t_protect();
    prog({4'hA, 7'h03}, 16'h1234, 1'h1, 1'h0);
    rd(7'h02, 16'hFFFF, 16'hFFFF);
  endtask
  task automatic t_write();
    en(11'h4C0);
    prog({4'hA, 7'h7F}, 16'hA5C3, 1'h1, 1'h1);
    prog({4'hA, 7'h00}, 16'h0F0F, 1'h1, 1'h1);
    rd(7'h7F, 16'hA5C3, 16'h0F0F);
  endtask
  task automatic t_erase_fill();
    prog(11'h440, 16'h3C5A, 1'h1, 1'h1);
    prog({4'hE, 7'h41}, 16'h0000, 1'h0, 1'h1);
    rd(7'h40, 16'h3C5A, 16'hFFFF);
    prog(11'h480, 16'h0000, 1'h0, 1'h1);
    rd(7'h20, 16'hFFFF, 16'hFFFF);
  endtask
  task automatic t_disable();
    en(11'h400);
    prog({4'hA, 7'h05}, 16'h0000, 1'h1, 1'h0);
    host.sel(1'h1);
    host.bit_x(1'h1, q);
    host.bit_x(1'h1, q);
    host.sel(1'h0);
    rd(7'h04, 16'hFFFF, 16'hFFFF);
  endtask
  // A reset in mid-run must drop write enable again, so a write after it is refused.
  task automatic t_reset();
    en(11'h4C0);
    @(posedge mclk_i) rst_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'h0;
    @(posedge mclk_i);
    chk1(oe_n, 1'h1);
    chk1(dout, 1'h1);
    prog({4'hA, 7'h06}, 16'h5555, 1'h1, 1'h0);
    rd(7'h06, 16'hFFFF, 16'hFFFF);
  endtask
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'h0;
    t_protect();
    t_write();
    t_erase_fill();
    t_disable();
    t_reset();
    wrap_up();
  end
endmodule // test_serial_eeprom_command_engine
